// ### tdla_params.svh
// texture download / address block constants
// assumes inclusion by tdla_top
`ifndef TDLA_PARAMS_SVH
`define TDLA_PARAMS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define TDLA_OFF_DATA      12'h000
`define TDLA_OFF_WPTR      12'h004
`define TDLA_OFF_BASE      12'h008
`define TDLA_OFF_FETCH     12'h00c
`define TDLA_OFF_FRAG      12'h010
`define TDLA_OFF_STATUS    12'h014
`define TDLA_OFF_LASTADDR  12'h018
`define TDLA_OFF_LASTBYTE  12'h01c
`define TDLA_OFF_CONV      12'h020

// ----------------------------------------
// texel fetch control fields
// ----------------------------------------
`define TDLA_FC_WLO_LSB    0
`define TDLA_FC_WMID_LSB   3
`define TDLA_FC_WHI_LSB    6
`define TDLA_FC_ORIGIN_BIT 9
`define TDLA_FC_BPT_LSB    10
`define TDLA_FC_FMT_LSB    12

// ----------------------------------------
// reset values
// ----------------------------------------
`define TDLA_RST_WPTR      24'h000000
`define TDLA_RST_BASE      24'h000000
`define TDLA_RST_FETCH     16'h0000
`define TDLA_RST_CONV      4'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define TDLA_FIFO_DEPTH    16
`define TDLA_ADDR_LAT      2

`endif

// ### tdla_pkg.sv
// types of the texture download / address block
// assumes tdla_params.svh beside it
`default_nettype none
package tdla_pkg;
  typedef enum logic [2:0] {
    TDLA_ADDR_IDLE = 3'b001,
    TDLA_ADDR_CALC = 3'b010,
    TDLA_ADDR_OUT  = 3'b100
  } tdla_addr_state_type;

  typedef enum logic [0:0] {
    TDLA_ORIGIN_BOTTOM = 1'b0,
    TDLA_ORIGIN_TOP    = 1'b1
  } tdla_origin_type;
endpackage : tdla_pkg
`default_nettype wire

// ### tdla_fifo.sv
// synchronous valid/ready fifo for downloaded words
// assumes a single clock and asynchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module tdla_fifo #(
  parameter int WIDTH = 56,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic [WIDTH-1:0] out_data_ff;
  logic             out_valid_ff;
  wire              push;
  wire              pop;
  wire              load_out;

  // ----------------------------------------
  // handshakes
  // ----------------------------------------
  assign load_out  = (count_ff != '0) && (!out_valid_ff || out_ready);
  assign push      = in_valid && in_ready;
  assign pop       = load_out;
  assign in_ready  = (count_ff != (AW+1)'(DEPTH));
  assign out_data  = out_data_ff;
  assign out_valid = out_valid_ff;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr_ff    <= '0;
      rd_ptr_ff    <= '0;
      count_ff     <= '0;
      out_valid_ff <= 1'b0;
      out_data_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff   <= rd_ptr_ff + 1'b1;
        out_data_ff <= mem_ff[rd_ptr_ff];
      end
      if (load_out) begin
        out_valid_ff <= 1'b1;
      end else if (out_ready) begin
        out_valid_ff <= 1'b0;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : tdla_fifo
`default_nettype wire

// ### tdla_top.sv
// texture memory front end: raw download path and texel address generator
// assumes an apb master on clk_sys, a texture memory write port, and a
// texture read stage that takes addresses with valid/ready
//
// Contract
// R1 - each downloaded word is 32 bits and stored exactly as written
// R2 - words go to consecutive addresses from the write pointer, which auto increments
// R3 - host supplies any patched layout itself; no patching here
// R4 - download needs no rasterizer setup and leaves pipeline state unchanged
// R5 - host sets colour conversion to texture format during formatted loads
// R6 - address stage produces S and T addresses and passes them to texture read
// R7 - bottom-left origin: address is base minus T times width plus S
// R8 - top-left origin: address is base plus T times width plus S
// R9 - map width limited to a supported subset, coded in three fields
// R10 - address map width is independent of wrap or clamp width and height
// R11 - byte address is texel address times bytes per texel
// R12 - any framebuffer format plus YUV and 4-bit index accepted
// R13 - fragments failing scissor or stipple never cause a texture access
// R14 - three width code fields map to the width through a fixed table
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "tdla_params.svh"
module tdla_top #(
  parameter int ADDR_W = 24,
  parameter int FDEPTH = `TDLA_FIFO_DEPTH
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic                        mem_wr_valid,
  output logic [ADDR_W-1:0]           mem_wr_addr,
  output logic [31:0]                 mem_wr_data,
  input  wire logic                   mem_wr_ready,
  input  wire logic                   frag_valid,
  input  wire logic                   frag_pass,
  input  wire logic [11:0]            frag_s,
  input  wire logic [11:0]            frag_t,
  output logic                        frag_ready,
  output logic                        tex_valid,
  output logic [ADDR_W-1:0]           tex_texel_addr,
  output logic [ADDR_W+1:0]           tex_byte_addr,
  output logic [3:0]                  tex_format,
  input  wire logic                   tex_ready,
  output logic [3:0]                  colour_conversion_control
);
  import tdla_pkg::*;

  // ----------------------------------------
  // width code table
  // ----------------------------------------
  // each code field selects zero or a power-of-two term; sum gives the map width
  function automatic logic [11:0] width_term(input logic [2:0] code);
    case (code)
      3'h0:    width_term = 12'h000;
      3'h1:    width_term = 12'h020;
      3'h2:    width_term = 12'h040;
      3'h3:    width_term = 12'h080;
      3'h4:    width_term = 12'h100;
      3'h5:    width_term = 12'h200;
      3'h6:    width_term = 12'h400;
      default: width_term = 12'h800;
    endcase
  endfunction : width_term

  function automatic logic [2:0] bytes_per_texel(input logic [1:0] code);
    case (code)
      2'h0:    bytes_per_texel = 3'h1;
      2'h1:    bytes_per_texel = 3'h2;
      2'h2:    bytes_per_texel = 3'h4;
      default: bytes_per_texel = 3'h4;
    endcase
  endfunction : bytes_per_texel

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [ADDR_W-1:0]   wptr_ff;
  logic [ADDR_W-1:0]   base_ff;
  logic [15:0]         fetch_ff;
  logic [3:0]          conv_ff;
  logic [31:0]         prdata_ff;
  logic                pready_ff;
  logic                pslverr_ff;
  logic [15:0]         frag_drop_ff;
  logic [ADDR_W-1:0]   last_addr_ff;
  logic [ADDR_W+1:0]   last_byte_ff;
  logic                mem_wr_valid_ff;
  logic [ADDR_W-1:0]   mem_wr_addr_ff;
  logic [31:0]         mem_wr_data_ff;
  tdla_addr_state_type state_ff;
  logic [11:0]         s_ff;
  logic [11:0]         t_ff;
  logic [ADDR_W-1:0]   prod_ff;
  logic                frag_ready_ff;
  logic                tex_valid_ff;
  logic [ADDR_W-1:0]   tex_texel_ff;
  logic [ADDR_W+1:0]   tex_byte_ff;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire       acc       = psel && penable;
  wire       sel_data  = (paddr == `TDLA_OFF_DATA);
  wire       sel_wptr  = (paddr == `TDLA_OFF_WPTR);
  wire       sel_base  = (paddr == `TDLA_OFF_BASE);
  wire       sel_fetch = (paddr == `TDLA_OFF_FETCH);
  wire       sel_frag  = (paddr == `TDLA_OFF_FRAG);
  wire       sel_stat  = (paddr == `TDLA_OFF_STATUS);
  wire       sel_last  = (paddr == `TDLA_OFF_LASTADDR);
  wire       sel_lbyte = (paddr == `TDLA_OFF_LASTBYTE);
  wire       sel_conv  = (paddr == `TDLA_OFF_CONV);
  wire       mapped    = sel_data || sel_wptr || sel_base || sel_fetch || sel_frag
                         || sel_stat || sel_last || sel_lbyte || sel_conv;
  wire       fifo_in_ready;
  // a data write waits in the access phase while the fifo is full
  wire       data_wr   = acc && pwrite && sel_data;
  wire       nxt_ready = acc && !pready_ff && (!data_wr || fifo_in_ready);
  // writes commit at the edge that completes the transfer
  wire       wr_fire   = acc && pready_ff && pwrite;
  wire       fifo_push = wr_fire && sel_data;

  // ----------------------------------------
  // download path
  // ----------------------------------------
  wire [ADDR_W+31:0] fifo_out_data;
  wire               fifo_out_valid;
  wire               fifo_out_ready = !mem_wr_valid_ff || mem_wr_ready;

  tdla_fifo #(
    .WIDTH (ADDR_W + 32),
    .DEPTH (FDEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_data   ({wptr_ff, pwdata}),  // R1
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready)
  );

  wire [ADDR_W-1:0] nxt_wptr = (wr_fire && sel_wptr) ? pwdata[ADDR_W-1:0] :
                               fifo_push ? wptr_ff + 1'b1 : wptr_ff;  // R2

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  wire [11:0] map_width = 12'(width_term(fetch_ff[`TDLA_FC_WLO_LSB +: 3])
                        + width_term(fetch_ff[`TDLA_FC_WMID_LSB +: 3])
                        + width_term(fetch_ff[`TDLA_FC_WHI_LSB +: 3]));  // R9 R14
  wire [31:0] nxt_rdata =
      sel_wptr  ? 32'(wptr_ff) :
      sel_base  ? 32'(base_ff) :
      sel_fetch ? 32'(fetch_ff) :
      sel_frag  ? 32'(frag_drop_ff) :
      sel_stat  ? {16'h0000, 3'h0, !fifo_in_ready, map_width} :
      sel_last  ? 32'(last_addr_ff) :
      sel_lbyte ? 32'(last_byte_ff) :
      sel_conv  ? 32'(conv_ff) : 32'h00000000;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else begin
      pready_ff  <= nxt_ready;
      pslverr_ff <= nxt_ready && !mapped;
      prdata_ff  <= (nxt_ready && !pwrite) ? nxt_rdata : 32'h00000000;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wptr_ff  <= `TDLA_RST_WPTR;
      base_ff  <= `TDLA_RST_BASE;
      fetch_ff <= `TDLA_RST_FETCH;
      conv_ff  <= `TDLA_RST_CONV;
    end else begin
      wptr_ff <= nxt_wptr;
      if (wr_fire && sel_base) begin
        base_ff <= pwdata[ADDR_W-1:0];
      end
      if (wr_fire && sel_fetch) begin
        fetch_ff <= pwdata[15:0];
      end
      if (wr_fire && sel_conv) begin
        conv_ff <= pwdata[3:0];  // R5
      end
    end
  end

  // memory write port: word and address pass unchanged
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_wr_valid_ff <= 1'b0;
      mem_wr_addr_ff  <= '0;
      mem_wr_data_ff  <= 32'h00000000;
    end else if (fifo_out_ready) begin
      mem_wr_valid_ff <= fifo_out_valid;
      if (fifo_out_valid) begin
        mem_wr_addr_ff <= fifo_out_data[ADDR_W+31:32];  // R2
        mem_wr_data_ff <= fifo_out_data[31:0];          // R1 R4
      end
    end
  end

  // ----------------------------------------
  // texel address generator
  // ----------------------------------------
  wire        origin_top = fetch_ff[`TDLA_FC_ORIGIN_BIT];
  wire [2:0]  bpt        = bytes_per_texel(fetch_ff[`TDLA_FC_BPT_LSB +: 2]);
  wire        take_frag  = frag_valid && frag_ready_ff;
  // operands widened first so the product is not cut to 12 bits
  wire [ADDR_W-1:0] prod = ADDR_W'(t_ff) * ADDR_W'(map_width);  // R10
  wire [ADDR_W-1:0] texel_addr = origin_top ? base_ff + prod_ff + ADDR_W'(s_ff)   // R8
                                            : base_ff - prod_ff + ADDR_W'(s_ff);  // R7
  wire [ADDR_W+1:0] byte_addr = (ADDR_W+2)'(texel_addr) * (ADDR_W+2)'(bpt);  // R11

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff      <= TDLA_ADDR_IDLE;
      frag_ready_ff <= 1'b1;
      tex_valid_ff  <= 1'b0;
      s_ff          <= 12'h000;
      t_ff          <= 12'h000;
      prod_ff       <= '0;
      tex_texel_ff  <= '0;
      tex_byte_ff   <= '0;
      frag_drop_ff  <= 16'h0000;
      last_addr_ff  <= '0;
      last_byte_ff  <= '0;
    end else begin
      case (state_ff)
        TDLA_ADDR_IDLE: begin
          if (take_frag && frag_pass) begin
            s_ff          <= frag_s;  // R6
            t_ff          <= frag_t;
            frag_ready_ff <= 1'b0;
            state_ff      <= TDLA_ADDR_CALC;
          end else if (take_frag) begin
            frag_drop_ff <= frag_drop_ff + 1'b1;  // R13
          end
        end
        TDLA_ADDR_CALC: begin
          prod_ff  <= prod;
          state_ff <= TDLA_ADDR_OUT;
        end
        TDLA_ADDR_OUT: begin
          if (!tex_valid_ff) begin
            tex_texel_ff <= texel_addr;
            tex_byte_ff  <= byte_addr;
            last_addr_ff <= texel_addr;
            last_byte_ff <= byte_addr;
            tex_valid_ff <= 1'b1;  // R6
          end else if (tex_ready) begin
            tex_valid_ff  <= 1'b0;
            frag_ready_ff <= 1'b1;
            state_ff      <= TDLA_ADDR_IDLE;
          end
        end
        default: state_ff <= TDLA_ADDR_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata                    = prdata_ff;
  assign pready                    = pready_ff;
  assign pslverr                   = pslverr_ff;
  assign mem_wr_valid              = mem_wr_valid_ff;
  assign mem_wr_addr               = mem_wr_addr_ff;
  assign mem_wr_data               = mem_wr_data_ff;
  assign frag_ready                = frag_ready_ff;
  assign tex_valid                 = tex_valid_ff;
  assign tex_texel_addr            = tex_texel_ff;
  assign tex_byte_addr             = tex_byte_ff;
  assign tex_format                = fetch_ff[`TDLA_FC_FMT_LSB +: 4];  // R12
  assign colour_conversion_control = conv_ff;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_word_unchanged;
    @(posedge clk_sys) disable iff (rst)
      (fifo_out_valid && fifo_out_ready) |=>
        mem_wr_valid && mem_wr_data == $past(fifo_out_data[31:0]);
  endproperty
  a_word_unchanged: assert property (p_word_unchanged) else $error("word not stored"); // R1

  property p_wptr_inc;
    @(posedge clk_sys) disable iff (rst)
      (fifo_push && !(wr_fire && sel_wptr)) |=> wptr_ff == $past(wptr_ff) + 1'b1;
  endproperty
  a_wptr_inc: assert property (p_wptr_inc) else $error("write pointer did not advance"); // R2

  property p_wptr_hold;
    @(posedge clk_sys) disable iff (rst)
      !wr_fire |=> $stable(wptr_ff);
  endproperty
  a_wptr_hold: assert property (p_wptr_hold) else $error("write pointer moved idle"); // R2

  property p_base_stable_dl;
    @(posedge clk_sys) disable iff (rst)
      fifo_push |=> $stable(base_ff) && $stable(fetch_ff);
  endproperty
  a_base_stable_dl: assert property (p_base_stable_dl) else $error("download changed state"); // R4

  property p_bottom;
    @(posedge clk_sys) disable iff (rst)
      $rose(tex_valid) && !origin_top |->
        tex_texel_addr == ADDR_W'(base_ff - ADDR_W'(t_ff) * ADDR_W'(map_width) + ADDR_W'(s_ff));
  endproperty
  a_bottom: assert property (p_bottom) else $error("bottom-left address wrong"); // R7

  property p_top;
    @(posedge clk_sys) disable iff (rst)
      $rose(tex_valid) && origin_top |->
        tex_texel_addr == ADDR_W'(base_ff + ADDR_W'(t_ff) * ADDR_W'(map_width) + ADDR_W'(s_ff));
  endproperty
  a_top: assert property (p_top) else $error("top-left address wrong"); // R8

  property p_bytes;
    @(posedge clk_sys) disable iff (rst)
      tex_valid |-> tex_byte_addr == (ADDR_W+2)'(tex_texel_addr) * (ADDR_W+2)'(bpt);
  endproperty
  a_bytes: assert property (p_bytes) else $error("byte address wrong"); // R11

  property p_no_access_fail;
    @(posedge clk_sys) disable iff (rst)
      (take_frag && !frag_pass) |=> state_ff == TDLA_ADDR_IDLE && !tex_valid;
  endproperty
  a_no_access_fail: assert property (p_no_access_fail) else $error("failed fragment fetched"); // R13

  property p_gen_latency;
    @(posedge clk_sys) disable iff (rst)
      (take_frag && frag_pass) |-> ##3 tex_valid;
  endproperty
  a_gen_latency: assert property (p_gen_latency) else $error("address late"); // R6

  c_download: cover property (@(posedge clk_sys) disable iff (rst) fifo_push ##[1:10] mem_wr_valid);
  c_fifo_full: cover property (@(posedge clk_sys) disable iff (rst) !fifo_in_ready);
  c_top_addr: cover property (@(posedge clk_sys) disable iff (rst) tex_valid && origin_top);
  c_drop: cover property (@(posedge clk_sys) disable iff (rst) take_frag && !frag_pass);
endmodule : tdla_top
`default_nettype wire

// ### tdla_far_model.sv
// far side model: texture memory write port and texture read stage
// assumes the bench drives the stall levels right after a clock edge
`timescale 1ns/1ps
`default_nettype none
module tdla_far_model (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        mem_wr_valid,
  input  wire logic [23:0] mem_wr_addr,
  input  wire logic [31:0] mem_wr_data,
  output logic             mem_wr_ready,
  input  wire logic        mem_stall,
  output logic             tex_ready,
  input  wire logic        tex_stall
);
  logic [23:0] addr_log [0:63];
  logic [31:0] data_log [0:63];
  int          mem_count;

  assign mem_wr_ready = !mem_stall;
  assign tex_ready    = !tex_stall;

  // logs the first 64 accepted words untouched
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_count <= 0;
    end else if (mem_wr_valid && mem_wr_ready && mem_count < 64) begin
      addr_log[mem_count] <= mem_wr_addr;
      data_log[mem_count] <= mem_wr_data;
      mem_count           <= mem_count + 1;
    end
  end
endmodule : tdla_far_model
`default_nettype wire

// ### texture_download_addressing_bench.sv
// bench for the texture download and texel address block
// assumes tdla_pkg, tdla_top and tdla_far_model compiled first
`timescale 1ns/1ps
`default_nettype none
module texture_download_addressing_bench;
  import tdla_pkg::*;
  logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, frag_s, frag_t;
  logic [31:0] pwdata, prdata, mem_wr_data;
  logic        mem_wr_valid, mem_wr_ready, frag_valid, frag_pass, frag_ready;
  logic        tex_valid, tex_ready, mem_stall, tex_stall;
  logic [23:0] mem_wr_addr, tex_texel_addr;
  logic [25:0] tex_byte_addr;
  logic [3:0]  tex_format, colour_conversion_control;
  int          mismatches, checks_done;

  tdla_top DUT (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_wr_valid(mem_wr_valid), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .mem_wr_ready(mem_wr_ready), .frag_valid(frag_valid), .frag_pass(frag_pass), .frag_s(frag_s),
    .frag_t(frag_t), .frag_ready(frag_ready), .tex_valid(tex_valid), .tex_texel_addr(tex_texel_addr),
    .tex_byte_addr(tex_byte_addr), .tex_format(tex_format), .tex_ready(tex_ready),
    .colour_conversion_control(colour_conversion_control));
  tdla_far_model far (.clk_sys(clk_sys), .rst(rst), .mem_wr_valid(mem_wr_valid),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .mem_wr_ready(mem_wr_ready),
    .mem_stall(mem_stall), .tex_ready(tex_ready), .tex_stall(tex_stall));

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic timeout;
    mismatches++;
    finish_test();
  endtask : timeout

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (n > 300) timeout();
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x);
  endtask : rd

  task automatic frag(input logic [11:0] s, input logic [11:0] t, input logic pass, output int lat);
    int n;
    @(posedge clk_sys);
    frag_valid <= 1'b1;
    frag_pass  <= pass;
    frag_s     <= s;
    frag_t     <= t;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (n > 100) timeout();
    end while (frag_ready !== 1'b1);
    frag_valid <= 1'b0;
    lat = 0;
    while (pass && tex_valid !== 1'b1) begin
      @(posedge clk_sys);
      lat++;
      if (lat > 50) timeout();
    end
  endtask : frag

  function automatic logic [31:0] wcode(input logic [2:0] c);
    return (c == 3'h0) ? 32'h0 : (32'h10 << c);
  endfunction : wcode

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [31:0] q;
    logic        e;
    rd(12'h004, 32'h0);
    rd(12'h008, 32'h0);
    rd(12'h00c, 32'h0);
    rd(12'h010, 32'h0);
    apb(1'b0, 12'h0fc, 32'h0, q, e);
    chk(e, 32'h1);
    chk(q, 32'h0);
    apb(1'b1, 12'h100, 32'hffffffff, q, e);
    chk(e, 32'h1);
    wr(12'h020, 32'h9);
    rd(12'h020, 32'h9);
    chk(colour_conversion_control, 32'h9);
  endtask : t_reset

  task automatic t_download;
    int          n;
    int          w;
    logic [31:0] q;
    logic        e;
    time         t0;
    mem_stall <= 1'b1;
    wr(12'h004, 32'h123);
    n = 0;
    do begin
      wr(12'h000, 32'ha5000000 + n);
      n++;
      apb(1'b0, 12'h014, 32'h0, q, e);
    end while (q[12] !== 1'b1 && n < 40);
    chk(32'(n >= 16), 32'h1);
    t0 = $time;
    fork
      begin
        repeat (30) @(posedge clk_sys);
        mem_stall <= 1'b0;
      end
      wr(12'h000, 32'ha5000000 + n);
    join
    chk(32'($time - t0 >= 300), 32'h1);
    n++;
    w = 0;
    while (far.mem_count < n) begin
      @(posedge clk_sys);
      w++;
      if (w > 300) timeout();
    end
    for (int i = 0; i < n; i++) begin
      chk(far.addr_log[i], 32'h123 + i);
      chk(far.data_log[i], 32'ha5000000 + i);
    end
    rd(12'h004, 32'h123 + n);
    rd(12'h008, 32'h0);
    chk(tex_valid, 32'h0);
  endtask : t_download

  task automatic t_addr;
    logic [2:0]  lo, mi, hi;
    logic [1:0]  bc;
    logic        org;
    logic [11:0] s, t;
    logic [31:0] wd, ex, eb;
    int          lat;
    wr(12'h008, 32'h4000);
    for (int f = 0; f < 16; f++) begin
      lo  = 3'(f % 7);
      mi  = 3'((f + 2) % 7);
      hi  = 3'((f * 3) % 7);
      org = 1'(f % 2);
      bc  = 2'(f % 4);
      s   = 12'(f * 291);
      t   = 12'(f * 37 + 1);
      wd  = wcode(lo) + wcode(mi) + wcode(hi);
      ex  = org ? (32'h4000 + t * wd + s) : (32'h4000 - t * wd + s);
      ex  = ex & 32'h00ffffff;
      eb  = (ex << ((bc == 2'h0) ? 0 : (bc == 2'h1) ? 1 : 2)) & 32'h03ffffff;
      wr(12'h00c, {16'h0, 4'(f), bc, org, hi, mi, lo});
      rd(12'h014, {20'h0, wd[11:0]});
      frag(s, t, 1'b1, lat);
      chk(lat, 32'h3);
      repeat (3) begin
        @(posedge clk_sys);
        chk(tex_valid, 32'h1);
      end
      chk(tex_texel_addr, ex);
      chk(tex_byte_addr, eb);
      chk(tex_format, 32'(f));
      tex_stall <= 1'b0;
      @(posedge clk_sys);
      tex_stall <= 1'b1;
      @(posedge clk_sys);
      chk(tex_valid, 32'h0);
      rd(12'h018, ex);
      rd(12'h01c, eb);
    end
  endtask : t_addr

  task automatic t_drop;
    int lat;
    frag(12'h010, 12'h020, 1'b0, lat);
    repeat (8) begin
      @(posedge clk_sys);
      chk(tex_valid, 32'h0);
    end
    rd(12'h010, 32'h1);
  endtask : t_drop

  // ----------------------------------------
  // clock, reset and sequence
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    mismatches  = 0;
    checks_done = 0;
    rst         = 1'b1;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h0;
    pwdata      = 32'h0;
    frag_valid  = 1'b0;
    frag_pass   = 1'b0;
    frag_s      = 12'h0;
    frag_t      = 12'h0;
    mem_stall   = 1'b0;
    tex_stall   = 1'b1;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_download();
    t_addr();
    t_drop();
    finish_test();
  end
endmodule : texture_download_addressing_bench
`default_nettype wire
